// file: hdl/wcc_top.sv
// Wiper position registers with cascade and disable handling
`timescale 1ns/1ps
`default_nettype none
module wcc_top
	import wcc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire wcc_cmd_t cmd_in,
	input wire logic [7:0] recall_data_in [NUM_POTS],
	input wire logic [1:0] rd_pot_in,
	output logic [7:0] rd_data_out,
	output logic [TAPS-1:0] tap_sel_out [NUM_POTS]
);
	wcc_pos_ctl_t pos_ctl_q [NUM_POTS];
	wcc_pos_ctl_t pos_ctl_d [NUM_POTS];
	logic [7:0] rd_data_q, rd_data_d;
	logic [TAPS-1:0] tap_q [NUM_POTS];
	logic [TAPS-1:0] tap_d [NUM_POTS];
	logic [1:0] nb_up, nb_dn;
	logic link_up, link_dn;
	wcc_pos_ctl_t cur;

	// Neighbour in chain exists only if cascade flags link them
	always_comb begin
		cur = pos_ctl_q[cmd_in.pot];
		nb_up = cmd_in.pot + 2'd1;
		nb_dn = cmd_in.pot - 2'd1;
		link_up = (cmd_in.pot != 2'd3) && cur.cascade;
		link_dn = (cmd_in.pot != 2'd0) && pos_ctl_q[nb_dn].cascade;
	end

	// Next values: one pot per command, two on a cascade crossing, recall loads all four
	always_comb begin
		for (int i = 0; i < NUM_POTS; i++) begin
			pos_ctl_d[i] = pos_ctl_q[i];
		end
		if (cmd_in.valid) begin
			unique case (cmd_in.op)
				WCC_OP_WRITE,
				WCC_OP_TRANSFER: begin
					pos_ctl_d[cmd_in.pot] = cmd_in.data;
				end
				WCC_OP_RECALL: begin
					for (int i = 0; i < NUM_POTS; i++) begin
						pos_ctl_d[i] = recall_data_in[i];
					end
				end
				WCC_OP_STEP: begin
					// Disabled pot of a chain does not step on its own
					if (!cur.disable_w) begin
						if (cmd_in.up) begin
							if (cur.pos != POS_MAX) begin
								pos_ctl_d[cmd_in.pot].pos = cur.pos + 6'd1;
							end else if (link_up) begin
								pos_ctl_d[cmd_in.pot].disable_w = 1'b1;
								pos_ctl_d[nb_up].disable_w = 1'b0;
								pos_ctl_d[nb_up].pos = POS_MIN;
							end
						end else begin
							if (cur.pos != POS_MIN) begin
								pos_ctl_d[cmd_in.pot].pos = cur.pos - 6'd1;
							end else if (link_dn) begin
								pos_ctl_d[cmd_in.pot].disable_w = 1'b1;
								pos_ctl_d[nb_dn].disable_w = 1'b0;
								pos_ctl_d[nb_dn].pos = POS_MAX;
							end
						end
					end
				end
			endcase
		end
		// Read path registered, so data lags the select by one cycle
		rd_data_d = pos_ctl_q[rd_pot_in];
	end

	// One-hot tap decode, all open when disabled
	generate
		for (genvar g = 0; g < NUM_POTS; g++) begin : g_tap
			always_comb begin
				tap_d[g] = '0;
				if (!pos_ctl_q[g].disable_w) begin
					tap_d[g][pos_ctl_q[g].pos] = 1'b1;
				end
			end
			assign tap_sel_out[g] = tap_q[g];
		end
	endgenerate

	// Reset clears all; power-up recall is a separate command
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < NUM_POTS; i++) begin
				pos_ctl_q[i] <= POS_CTL_RESET;
				tap_q[i] <= '0;
			end
			rd_data_q <= 8'h00;
		end else begin
			for (int i = 0; i < NUM_POTS; i++) begin
				pos_ctl_q[i] <= pos_ctl_d[i];
				tap_q[i] <= tap_d[i];
			end
			rd_data_q <= rd_data_d;
		end
	end
	assign rd_data_out = rd_data_q;

	// Step requests on an enabled wiper, one per direction
	sequence s_step_up;
		cmd_in.valid && cmd_in.op == WCC_OP_STEP && cmd_in.up &&
		!cur.disable_w;
	endsequence

	sequence s_step_dn;
		cmd_in.valid && cmd_in.op == WCC_OP_STEP && !cmd_in.up &&
		!cur.disable_w;
	endsequence

	a_tap_off: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		pos_ctl_q[0].disable_w |=> (tap_q[0] == '0))
		else $error("tap closed while disabled");

	a_tap_onehot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!pos_ctl_q[1].disable_w |=> $onehot(tap_q[1]))
		else $error("tap not one-hot");

	a_write_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_WRITE
		|=> pos_ctl_q[$past(cmd_in.pot)] == $past(cmd_in.data))
		else $error("write not loaded");

	a_transfer_load: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_TRANSFER
		|=> pos_ctl_q[$past(cmd_in.pot)] == $past(cmd_in.data))
		else $error("transfer not loaded");

	a_recall_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_RECALL
		|=> pos_ctl_q[2] == $past(recall_data_in[2]))
		else $error("recall not loaded");

	a_step_up: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_STEP && cmd_in.up &&
		!cur.disable_w && cur.pos != POS_MAX
		|=> pos_ctl_q[$past(cmd_in.pot)].pos == $past(cur.pos) + 6'd1)
		else $error("step up wrong");

	a_step_down: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		s_step_dn ##0 (cur.pos != POS_MIN)
		|=> pos_ctl_q[$past(cmd_in.pot)].pos == $past(cur.pos) - 6'd1)
		else $error("step down wrong");

	a_sat_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_STEP && !cmd_in.up &&
		cmd_in.pot == 2'd0 && cur.pos == POS_MIN
		|=> pos_ctl_q[0].pos == POS_MIN)
		else $error("wrapped at bottom");

	a_sat_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		s_step_up ##0 (cmd_in.pot == 2'd3 && cur.pos == POS_MAX)
		|=> pos_ctl_q[3].pos == POS_MAX)
		else $error("wrapped at top");

	a_cross_up: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_STEP && cmd_in.up &&
		!cur.disable_w && cur.pos == POS_MAX && link_up
		|=> pos_ctl_q[$past(nb_up)].disable_w == 1'b0 &&
		pos_ctl_q[$past(cmd_in.pot)].disable_w)
		else $error("boundary not crossed");

	// Crossing down lands on the top tap of the lower array
	a_cross_down: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		s_step_dn ##0 (cur.pos == POS_MIN && link_dn)
		|=> pos_ctl_q[$past(nb_dn)].disable_w == 1'b0 &&
		pos_ctl_q[$past(nb_dn)].pos == POS_MAX &&
		pos_ctl_q[$past(cmd_in.pot)].disable_w)
		else $error("boundary not crossed down");

	// A step sent to disabled wiper 0 must leave pots 0 and 1 unchanged
	a_off_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_STEP && cmd_in.pot == 2'd0 &&
		pos_ctl_q[0].disable_w
		|=> $stable(pos_ctl_q[0]) && $stable(pos_ctl_q[1]))
		else $error("disabled wiper stepped");

	a_lone_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cmd_in.valid && cmd_in.op == WCC_OP_STEP && cmd_in.pot == 2'd1 &&
		!cur.cascade && !pos_ctl_q[0].cascade
		|=> $stable(pos_ctl_q[2]) && $stable(pos_ctl_q[0]))
		else $error("lone pot touched neighbour");

	a_read_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		1'b1 |=> rd_data_q[DISABLE_BIT] ==
		$past(pos_ctl_q[rd_pot_in].disable_w))
		else $error("read flag wrong");

	a_read_cascade: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		1'b1 |=> rd_data_q[CASCADE_BIT] ==
		$past(pos_ctl_q[rd_pot_in].cascade))
		else $error("read cascade flag wrong");

	// Enabled wiper closes the switch of its own position
	generate
		for (genvar g = 0; g < NUM_POTS; g++) begin : g_tap_chk
			a_tap_match: assert property (@(posedge sys_clk_in)
				disable iff (rst_in)
				!pos_ctl_q[g].disable_w |=>
				tap_q[g][$past(pos_ctl_q[g].pos)])
				else $error("tap not at wiper position");
		end
	endgenerate
endmodule
`default_nettype wire

// file: hdl/wcc_pkg.sv
// Package for the wiper cascade control block
package wcc_pkg;
	localparam int NUM_POTS = 4;
	localparam int POS_W = 6;
	localparam int TAPS = 64;
	localparam int POS_LSB = 0;
	localparam int DISABLE_BIT = 6;
	localparam int CASCADE_BIT = 7;
	localparam logic [5:0] POS_MAX = 6'h3f;
	localparam logic [5:0] POS_MIN = 6'h00;
	localparam logic [7:0] POS_CTL_RESET = 8'h00;

	typedef enum logic [1:0] {
		WCC_OP_WRITE,
		WCC_OP_TRANSFER,
		WCC_OP_STEP,
		WCC_OP_RECALL
	} wcc_op_t;

	typedef struct packed {
		logic cascade;
		logic disable_w;
		logic [5:0] pos;
	} wcc_pos_ctl_t;

	typedef struct packed {
		logic valid;
		wcc_op_t op;
		logic [1:0] pot;
		logic up;
		logic [7:0] data;
	} wcc_cmd_t;
endpackage

// file: verif/wcc_host_model.sv
// Host master model that issues wiper commands
`timescale 1ns/1ps
`default_nettype none
module wcc_host_model
	import wcc_pkg::*;
(
	input wire logic sys_clk_in,
	output var wcc_cmd_t cmd_out
);
	initial cmd_out = '0;
	// Falling-edge launch keeps the taking edge clean
	task automatic send(input wcc_op_t op, input logic [1:0] pot,
		input logic up, input logic [7:0] data);
		@(negedge sys_clk_in);
		cmd_out = '{1'b1, op, pot, up, data};
		@(negedge sys_clk_in);
		cmd_out = '0;
	endtask
endmodule
`default_nettype wire

// file: verif/test_wcc_top.sv
// Testbench for the wiper cascade control block
`timescale 1ns/1ps
`default_nettype none
module test_wcc_top
	import wcc_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [1:0] rd_pot_in = 2'h0;
	logic [7:0] recall_data_in [NUM_POTS] = '{8'h11, 8'h22, 8'h33, 8'h3f};
	logic [7:0] rd_data_out;
	logic [TAPS-1:0] tap_sel_out [NUM_POTS];
	wcc_cmd_t cmd_in;
	int errors = 0;
	int check_count = 0;
	wcc_host_model host (.sys_clk_in(sys_clk_in), .cmd_out(cmd_in));
	wcc_top dut (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.cmd_in(cmd_in),
		.recall_data_in(recall_data_in),
		.rd_pot_in(rd_pot_in),
		.rd_data_out(rd_data_out),
		.tap_sel_out(tap_sel_out)
	);
	initial begin
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	task automatic print_verdict();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] seen);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Two edges: one to register the read data, one to settle
	task automatic rd(input logic [1:0] p, input logic [7:0] exp,
		input logic [7:0] msk);
		@(negedge sys_clk_in);
		rd_pot_in = p;
		repeat (2) @(negedge sys_clk_in);
		chk("pos_ctl", {56'h0, exp}, {56'h0, rd_data_out & msk});
	endtask
	initial begin
		repeat (2000) @(negedge sys_clk_in);
		errors++;
		print_verdict();
	end
	initial begin
		repeat (8) @(negedge sys_clk_in);
		rst_in = 1'b0;
		host.send(WCC_OP_WRITE, 2'd1, 1'b0, 8'h05);
		rd(2'd1, 8'h05, 8'hff);
		chk("tap1", 64'h20, tap_sel_out[1]);
		host.send(WCC_OP_TRANSFER, 2'd0, 1'b0, 8'h45);
		rd(2'd0, 8'h45, 8'hff);
		chk("tap0", 64'h0, tap_sel_out[0]);
		host.send(WCC_OP_WRITE, 2'd0, 1'b0, 8'hbf);
		host.send(WCC_OP_WRITE, 2'd1, 1'b0, 8'h40);
		host.send(WCC_OP_STEP, 2'd0, 1'b1, 8'h00);
		rd(2'd1, 8'h00, 8'hff);
		chk("tap1", 64'h1, tap_sel_out[1]);
		rd(2'd0, 8'hc0, 8'hc0);
		chk("tap0", 64'h0, tap_sel_out[0]);
		host.send(WCC_OP_STEP, 2'd0, 1'b1, 8'h00);
		rd(2'd0, 8'hff, 8'hff);
		host.send(WCC_OP_STEP, 2'd1, 1'b0, 8'h00);
		rd(2'd0, 8'hbf, 8'hff);
		chk("tap0", {1'b1, 63'h0}, tap_sel_out[0]);
		host.send(WCC_OP_RECALL, 2'd0, 1'b0, 8'h00);
		for (int i = 0; i < NUM_POTS; i++) begin
			rd(2'(i), recall_data_in[i], 8'hff);
		end
		chk("tap3", {1'b1, 63'h0}, tap_sel_out[3]);
		chk("tap2", 64'h0008000000000000, tap_sel_out[2]);
		host.send(WCC_OP_STEP, 2'd1, 1'b1, 8'h00);
		rd(2'd1, 8'h23, 8'hff);
		rd(2'd0, 8'h11, 8'hff);
		host.send(WCC_OP_STEP, 2'd1, 1'b0, 8'h00);
		rd(2'd1, 8'h22, 8'hff);
		host.send(WCC_OP_STEP, 2'd3, 1'b1, 8'h00);
		rd(2'd3, 8'h3f, 8'hff);
		host.send(WCC_OP_WRITE, 2'd2, 1'b0, 8'h00);
		host.send(WCC_OP_STEP, 2'd2, 1'b0, 8'h00);
		rd(2'd2, 8'h00, 8'hff);
		// Host keeps its own copy of positions across power loss
		recall_data_in = '{8'h11, 8'h22, 8'h00, 8'h3f};
		rst_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		rst_in = 1'b0;
		rd(2'd3, 8'h00, 8'hff);
		host.send(WCC_OP_RECALL, 2'd0, 1'b0, 8'h00);
		for (int i = 0; i < NUM_POTS; i++) begin
			rd(2'(i), recall_data_in[i], 8'hff);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
